// >>> common/npw_pkg.sv
/*
 * Shared types of the nonvolatile potentiometer controller.
 * Assumes the constants header npw_map.svh is available on the include path.
 */
package npw_pkg;
    typedef enum logic [3:0] {
        NPW_LOAD,
        NPW_IDLE,
        NPW_DEVADR,
        NPW_ACK_DEV,
        NPW_MEMADR,
        NPW_ACK_MEM,
        NPW_WDATA,
        NPW_ACK_DATA,
        NPW_RDATA,
        NPW_RACK,
        NPW_SKIP
    } npw_state_t;
endpackage

// >>> common/npw_map.svh
/*
 * Constants of the nonvolatile potentiometer controller: address prefix,
 * wiper register addresses, power-up wiper value and timing.
 * Assumes a 50 MHz system clock.
 */
`ifndef NPW_MAP_SVH
`define NPW_MAP_SVH
`define NPW_DEV_PREFIX 6'h28
`define NPW_POT1_ADDR 8'hF8
`define NPW_POT0_ADDR 8'hF9
`define NPW_POT2_ADDR 8'hFA
`define NPW_WIPER_DEFAULT 7'h7F
`define NPW_POS_MASK 8'h7F
`define NPW_PAGE_BYTES 8
`define NPW_CLK_HZ 50000000
`define NPW_PROG_TIME_MS 10
`define NPW_PROG_CYCLES ((`NPW_PROG_TIME_MS * `NPW_CLK_HZ) / 1000)
`define NPW_LOAD_CYCLES 4
`endif

// >>> logic/npw_nv_store.sv
/*
 * Nonvolatile wiper store: three seven-bit cells with a timed program cycle.
 * Assumes the controller raises prog_start_i only while busy_o is low.
 */
`timescale 1ns/10ps
`include "npw_map.svh"
module npw_nv_store #(
    parameter int PROG_CYCLES = `NPW_PROG_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic prog_start_i,
    input wire logic [2:0] prog_sel_i,
    input wire logic [20:0] prog_data_i,
    output logic busy_o,
    output logic [20:0] cells_o
);
    // cells get the factory value only at first power-up, never from rst_i
    logic [20:0] cells = {3{`NPW_WIPER_DEFAULT}};
    logic [20:0] next_cells;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [2:0] sel;
    logic [2:0] next_sel;
    logic [20:0] data;
    logic [20:0] next_data;

    // ************************************************
    // program timer; cells model eeprom, so reset keeps them
    // ************************************************
    always_comb begin
        next_cells = cells;
        next_cnt = cnt;
        next_sel = sel;
        next_data = data;
        if (prog_start_i && cnt == 32'h0) begin
            next_cnt = 32'(PROG_CYCLES);
            next_sel = prog_sel_i;
            next_data = prog_data_i;
        end else if (cnt == 32'h1) begin
            next_cnt = 32'h0;
            for (int i = 0; i < 3; i++) begin
                if (sel[i]) begin
                    next_cells[i*7 +: 7] = data[i*7 +: 7];
                end
            end
        end else if (cnt != 32'h0) begin
            next_cnt = cnt - 32'h1;
        end
    end

    // cell update is not gated by reset, so stored settings survive it
    always_ff @(posedge clk_i) begin
        cells <= next_cells;
        if (rst_i) begin
            cnt <= 32'h0;
            sel <= 3'h0;
            data <= 21'h0;
        end else begin
            cnt <= next_cnt;
            sel <= next_sel;
            data <= next_data;
        end
    end

    assign busy_o = (cnt != 32'h0);
    assign cells_o = cells;
endmodule

// >>> logic/npw_ctrl.sv
/*
 * Two-wire slave controller of a triple nonvolatile potentiometer, with
 * write protect, page writes, reads and a timed nonvolatile program cycle.
 * Assumes scl/sda inputs are already synchronous and glitch free.
 */
`timescale 1ns/10ps
`include "npw_map.svh"
module npw_ctrl
    import npw_pkg::*;
#(
    parameter int PROG_CYCLES = `NPW_PROG_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic bus_address_strap_i,
    input wire logic write_protect_i,
    output logic [6:0] wiper0_o,
    output logic [6:0] wiper1_o,
    output logic [6:0] wiper2_o,
    output logic nv_busy_o
);
    npw_state_t state;
    npw_state_t next_state;
    logic scl_d;
    logic sda_d;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [3:0] bitcnt;
    logic [3:0] next_bitcnt;
    logic [7:0] addr;
    logic [7:0] next_addr;
    logic [20:0] pend;
    logic [20:0] next_pend;
    logic [2:0] dirty;
    logic [2:0] next_dirty;
    logic drive_low;
    logic next_drive_low;
    logic [2:0] ldcnt;
    logic [2:0] next_ldcnt;
    logic [20:0] wipers;
    logic [20:0] next_wipers;
    logic prog_start;
    logic busy;
    logic [20:0] cells;
    logic start_c;
    logic stop_c;
    logic scl_rise;
    logic scl_fall;

    // maps a register address to its wiper slot; 3 means none
    function automatic logic [1:0] slot(input logic [7:0] a);
        if (a == `NPW_POT0_ADDR) begin
            slot = 2'd0;
        end else if (a == `NPW_POT1_ADDR) begin
            slot = 2'd1;
        end else if (a == `NPW_POT2_ADDR) begin
            slot = 2'd2;
        end else begin
            slot = 2'd3;
        end
    endfunction

    // advance inside the eight-byte page
    function automatic logic [7:0] page_next(input logic [7:0] a);
        page_next = {a[7:3], a[2:0] + 3'h1};
    endfunction

    npw_nv_store #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .prog_start_i(prog_start),
        .prog_sel_i(dirty),
        .prog_data_i(pend),
        .busy_o(busy),
        .cells_o(cells)
    );

    // ************************************************
    // bus condition detection
    // ************************************************
    assign start_c = scl_i && scl_d && sda_d && !sda_i;
    assign stop_c = scl_i && scl_d && !sda_d && sda_i;
    assign scl_rise = scl_i && !scl_d;
    assign scl_fall = !scl_i && scl_d;
    // program request fires on stop with pending data
    assign prog_start = stop_c && (dirty != 3'h0) && !busy;

    // ************************************************
    // protocol engine
    // ************************************************
    always_comb begin
        logic [1:0] s;
        logic [7:0] rd;
        s = slot(addr);
        rd = (s == 2'd3) ? 8'h00 : {1'b0, wipers[s*7 +: 7]};
        next_state = state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_addr = addr;
        next_pend = pend;
        next_dirty = dirty;
        next_drive_low = drive_low;
        next_ldcnt = ldcnt;
        next_wipers = wipers;
        if (state == NPW_LOAD) begin
            next_wipers = cells;
            next_pend = cells;
            next_ldcnt = ldcnt + 3'h1;
            if (ldcnt == 3'(`NPW_LOAD_CYCLES - 1)) begin
                next_state = NPW_IDLE;
            end
        end else if (busy) begin
            // inputs disabled while programming
            next_state = NPW_IDLE;
            next_drive_low = 1'b0;
            next_dirty = 3'h0;
            next_wipers = cells;
            next_pend = cells;
        end else if (stop_c) begin
            next_state = NPW_IDLE;
            next_drive_low = 1'b0;
            next_dirty = 3'h0; // handed to the store this cycle
        end else if (start_c) begin
            next_state = NPW_DEVADR;
            next_bitcnt = 4'h0;
            next_drive_low = 1'b0;
            next_pend = wipers; // uncommitted data dropped on restart
            next_dirty = 3'h0;
        end else begin
            case (state)
                NPW_DEVADR, NPW_MEMADR, NPW_WDATA: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_i}; // msb first
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    if (scl_fall && bitcnt == 4'h8) begin
                        next_bitcnt = 4'h0;
                        if (state == NPW_DEVADR) begin
                            if (shreg[7:1] == {`NPW_DEV_PREFIX, bus_address_strap_i}) begin
                                next_state = NPW_ACK_DEV;
                                next_drive_low = 1'b1;
                            end else begin
                                next_state = NPW_SKIP;
                            end
                        end else if (state == NPW_MEMADR) begin
                            next_addr = shreg;
                            next_state = NPW_ACK_MEM;
                            next_drive_low = 1'b1;
                        end else begin
                            // write protect low required; high or open locks
                            if (!write_protect_i && s != 2'd3) begin
                                next_pend[s*7 +: 7] = 7'(shreg & `NPW_POS_MASK);
                                next_dirty[s] = 1'b1;
                            end
                            next_addr = page_next(addr);
                            next_state = NPW_ACK_DATA;
                            next_drive_low = 1'b1;
                        end
                    end
                end
                NPW_ACK_DEV, NPW_ACK_MEM, NPW_ACK_DATA: begin
                    if (scl_fall) begin
                        next_drive_low = 1'b0;
                        if (state == NPW_ACK_DEV && shreg[0]) begin
                            next_state = NPW_RDATA;
                            next_shreg = rd;
                            next_drive_low = !rd[7];
                            next_bitcnt = 4'h1;
                        end else if (state == NPW_ACK_DEV) begin
                            next_state = NPW_MEMADR;
                        end else begin
                            next_state = NPW_WDATA;
                        end
                    end
                end
                NPW_RDATA: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h8) begin
                            next_state = NPW_RACK;
                            next_drive_low = 1'b0;
                            next_addr = addr + 8'h01; // wraps at ff
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_drive_low = !shreg[6];
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                NPW_RACK: begin
                    if (scl_rise) begin
                        next_shreg = {7'h0, sda_i};
                    end
                    if (scl_fall) begin
                        if (!shreg[0]) begin
                            next_state = NPW_RDATA;
                            next_shreg = rd;
                            next_drive_low = !rd[7];
                            next_bitcnt = 4'h1;
                        end else begin
                            next_state = NPW_SKIP;
                        end
                    end
                end
                NPW_IDLE: begin
                    // cells change on the last busy edge, so copy them once idle
                    next_wipers = cells;
                    next_pend = cells;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= NPW_LOAD;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            addr <= 8'h00;
            pend <= 21'h0;
            dirty <= 3'h0;
            drive_low <= 1'b0;
            ldcnt <= 3'h0;
            wipers <= 21'h0;
        end else begin
            state <= next_state;
            scl_d <= scl_i;
            sda_d <= sda_i;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            addr <= next_addr;
            pend <= next_pend;
            dirty <= next_dirty;
            drive_low <= next_drive_low;
            ldcnt <= next_ldcnt;
            wipers <= next_wipers;
        end
    end

    // open drain: enable low means pulling sda low
    assign sda_o = 1'b0;
    assign sda_oe_n_o = !drive_low;
    assign wiper0_o = wipers[6:0];
    assign wiper1_o = wipers[13:7];
    assign wiper2_o = wipers[20:14];
    assign nv_busy_o = busy;
endmodule

// >>> dv/npw_ctrl_props.sv
/* Port checker for npw_ctrl.
   Assumes it is bound to npw_ctrl with the same PROG_CYCLES. */
`timescale 1ns/10ps
module npw_ctrl_props #(
    parameter int PROG_CYCLES = 400
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic bus_address_strap_i,
    input wire logic write_protect_i,
    input wire logic [6:0] wiper0_o,
    input wire logic [6:0] wiper1_o,
    input wire logic [6:0] wiper2_o,
    input wire logic nv_busy_o
);
    // ****
    // helper counters
    // ****
    logic [31:0] busy_cnt;
    logic [31:0] next_busy_cnt;
    logic [2:0] since_rst;
    logic [2:0] next_since_rst;
    // since_rst saturates so the load phase is masked out once after each reset
    always_comb begin
        next_busy_cnt = nv_busy_o ? busy_cnt + 32'h1 : 32'h0;
        next_since_rst = rst_i ? 3'h0 : (since_rst == 3'h7 ? 3'h7 : since_rst + 3'h1);
    end
    always_ff @(posedge clk_i) begin
        busy_cnt <= next_busy_cnt;
        since_rst <= next_since_rst;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_busy_nack; nv_busy_o |-> sda_oe_n_o; endproperty
    a_busy_nack: assert property (p_busy_nack)
        else $error("acknowledge driven during program cycle");
    property p_load; $fell(rst_i) |-> sda_oe_n_o [*4]; endproperty
    a_load: assert property (p_load)
        else $error("bus answered during load phase");
    property p_busy_stop; $rose(nv_busy_o) |-> scl_i && sda_i && sda_oe_n_o; endproperty
    a_busy_stop: assert property (p_busy_stop)
        else $error("program cycle began without a stop");
    property p_busy_wp; $rose(nv_busy_o) |-> !write_protect_i; endproperty
    a_busy_wp: assert property (p_busy_wp)
        else $error("program cycle while write protect high");
    property p_busy_len;
        $fell(nv_busy_o) |-> busy_cnt >= PROG_CYCLES - 1 && busy_cnt <= PROG_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("program cycle length wrong");
    property p_busy_min; $rose(nv_busy_o) |=> nv_busy_o [*8]; endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("program cycle too short");
    property p_wiper_hold;
        since_rst == 3'h7 && $changed({wiper0_o, wiper1_o, wiper2_o})
            |-> $past(nv_busy_o) || $past(nv_busy_o, 2);
    endproperty
    a_wiper_hold: assert property (p_wiper_hold)
        else $error("wiper moved outside a program cycle end");
    property p_sda_scl; $changed(sda_oe_n_o) |-> !scl_i; endproperty
    a_sda_scl: assert property (p_sda_scl)
        else $error("data line moved while bus clock high");
endmodule

// >>> dv/npw_bus_master.sv
/* Two-wire bus master model for the controller's serial port.
   Assumes the bench resolves the open-drain data line with a pull-up. */
`timescale 1ns/10ps
`include "npw_map.svh"
module npw_bus_master (
    input wire logic clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_rel_o
);
    // ****
    // bus phases, changed only at falling clock edges
    // ****
    initial begin
        scl_o = 1'b1;
        sda_rel_o = 1'b1;
    end
    // quarter bit of four clocks leaves room for the one-clock ack turnaround
    task automatic qtr();
        repeat (4) @(negedge clk_i);
    endtask
    task automatic start();
        sda_rel_o = 1'b1;
        qtr();
        sda_rel_o = 1'b0;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask
    task automatic stop();
        sda_rel_o = 1'b0;
        qtr();
        scl_o = 1'b1;
        qtr();
        sda_rel_o = 1'b1;
        qtr();
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_rel_o = b;
        qtr();
        scl_o = 1'b1;
        qtr();
        r = sda_line_i;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r); // msb first
        xbit(1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r); // msb first
            d[i] = r;
        end
        xbit(last, r); // low asks for more, high ends the read
    endtask
    task automatic adr(input logic s, input logic rw, output logic ack);
        wr_byte({`NPW_DEV_PREFIX, s, rw}, ack);
    endtask
endmodule

// >>> dv/npw_ctrl_tb_top.sv
/* Self-checking bench for npw_ctrl driven through npw_bus_master.
   Assumes design, master model and checker are compiled before it. */
`timescale 1ns/10ps
module npw_ctrl_tb_top;
    localparam int PROG = 400;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic strap = 1'b0;
    logic wp_gnd = 1'b0;
    tri1 wp_line;
    wire scl;
    wire sda_rel;
    wire sda_line;
    logic sda_o;
    logic sda_oe_n_o;
    logic [6:0] w0;
    logic [6:0] w1;
    logic [6:0] w2;
    logic busy;
    logic ok;
    logic [7:0] pg [8];
    int error_cnt = 0;
    int compares = 0;
    // ****
    // clock, pins and instances
    // ****
    always #10 clk_i = ~clk_i;
    // open write protect pin floats up to high
    assign wp_line = wp_gnd ? 1'b0 : 1'bz;
    assign sda_line = sda_rel & (sda_oe_n_o | sda_o);
    npw_bus_master mst (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_rel_o(sda_rel));
    npw_ctrl #(.PROG_CYCLES(PROG)) DUT (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .bus_address_strap_i(strap), .write_protect_i(wp_line), .wiper0_o(w0),
        .wiper1_o(w1), .wiper2_o(w2), .nv_busy_o(busy));
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 2000 && busy !== 1'b0; i++) ticks(1);
        if (i == 2000) begin
            error_cnt++;
            results();
        end
        ticks(2); // wipers follow the cells one clock after busy drops
    endtask
    task automatic xfer(input logic s, input logic [7:0] mem, input int n, output logic acked);
        logic a;
        mst.start();
        mst.adr(s, 1'b0, acked);
        if (acked) begin
            mst.wr_byte(mem, a);
            acked &= a;
            for (int i = 0; i < n; i++) begin
                mst.wr_byte(pg[i], a);
                acked &= a;
            end
        end
        chk("busy before stop", 24'h0, {23'h0, busy});
        mst.stop();
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_byte();
        wp_gnd = 1'b1;
        pg[0] = 8'h82;
        xfer(1'b0, 8'hF9, 1, ok);
        chk("write ack", 24'h1, {23'h0, ok});
        ticks(3);
        chk("busy after stop", 24'h1, {23'h0, busy});
        mst.start();
        mst.adr(1'b0, 1'b0, ok);
        chk("poll ack", 24'h0, {23'h0, ok});
        mst.stop();
        wait_idle();
        chk("wipers", {3'h0, 7'h7F, 7'h7F, 7'h02}, {3'h0, w2, w1, w0});
    endtask
    task automatic t_wp();
        wp_gnd = 1'b0;
        pg[0] = 8'h11;
        xfer(1'b0, 8'hF8, 1, ok);
        chk("protected ack", 24'h1, {23'h0, ok});
        ticks(10);
        chk("protected busy", 24'h0, {23'h0, busy});
        chk("wipers", {3'h0, 7'h7F, 7'h7F, 7'h02}, {3'h0, w2, w1, w0});
        wp_gnd = 1'b1;
        rst_i = 1'b1;
        ticks(2);
        rst_i = 1'b0;
        ticks(6);
        chk("wipers", {3'h0, 7'h7F, 7'h7F, 7'h02}, {3'h0, w2, w1, w0});
    endtask
    task automatic t_strap();
        xfer(1'b1, 8'hF9, 0, ok);
        chk("foreign strap", 24'h0, {23'h0, ok});
        strap = 1'b1;
        xfer(1'b1, 8'hF9, 0, ok);
        chk("own strap", 24'h1, {23'h0, ok});
        ticks(10);
        chk("busy no data", 24'h0, {23'h0, busy});
        strap = 1'b0;
    endtask
    task automatic t_page();
        for (int i = 0; i < 8; i++) pg[i] = 8'h90 + 8'(i);
        xfer(1'b0, 8'hFA, 8, ok);
        chk("page ack", 24'h1, {23'h0, ok});
        ticks(3);
        wait_idle();
        chk("wipers", {3'h0, 7'h10, 7'h16, 7'h17}, {3'h0, w2, w1, w0});
    endtask
    // current address read after the page: wrapped address is pot2, then unmapped
    task automatic t_read();
        logic [7:0] d;
        mst.start();
        mst.adr(1'b0, 1'b1, ok);
        chk("read ack", 24'h1, {23'h0, ok});
        mst.rd_byte(1'b0, d);
        chk("read pot2", 24'h10, {16'h0, d});
        mst.rd_byte(1'b1, d);
        chk("read unmapped", 24'h0, {16'h0, d});
        mst.stop();
    endtask
    initial begin
        ticks(8);
        rst_i = 1'b0;
        ticks(6);
        chk("wipers", {3'h0, 7'h7F, 7'h7F, 7'h7F}, {3'h0, w2, w1, w0});
        t_byte();
        t_wp();
        t_strap();
        t_page();
        t_read();
        results();
    end
endmodule
bind npw_ctrl npw_ctrl_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.clk_i(clk_i),
    .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .bus_address_strap_i(bus_address_strap_i), .write_protect_i(write_protect_i),
    .wiper0_o(wiper0_o), .wiper1_o(wiper1_o), .wiper2_o(wiper2_o), .nv_busy_o(nv_busy_o));
